// ### shared/bsp_pkg.sv
// Shared constants and types of the strap and pin select block
package bsp_pkg;
  localparam int         AW         = 8;
  localparam int         NREQ       = 6;
  localparam int         NCLK       = 7;
  localparam int         NINT       = 4;
  localparam int         NGP        = 4;
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_GPO    = 8'h08;
  localparam logic [7:0] OFS_PINS   = 8'h0c;
  localparam logic [7:0] OFS_INTD   = 8'h10;
  localparam logic [7:0] OFS_CMSK   = 8'h14;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
  localparam logic [6:0] CMSK_RST   = 7'h7f;
  localparam logic [5:0] GNT_IDLE   = 6'h3f;
  localparam logic [3:0] IR_IDCODE  = 4'h1;
  localparam logic [3:0] IR_MFG     = 4'h8;
  localparam logic [3:0] IR_BYPASS  = 4'hf;
  localparam logic [3:0] IR_CAPT    = 4'h1;
  // Arbitrary value
  localparam logic [31:0] IDCODE_VAL = 32'h0000_0001;

  typedef struct packed {
    logic hotplug;
    logic ext_arb;
    logic reverse;
    logic nontrans;
    logic smbus;
    logic test;
  } bsp_mode_t;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SDR, ST_CDR, ST_SHDR, ST_E1DR, ST_PDR, ST_E2DR,
    ST_UDR, ST_SIR, ST_CIR, ST_SHIR, ST_E1IR, ST_PIR, ST_E2IR, ST_UIR
  } bsp_tap_st_t;
endpackage

// ### shared/bsp_tap_if.sv
// Carrier between the top and the scan port controller
`timescale 1ns/100ps
interface bsp_tap_if;
  logic       tck_rise;
  logic       tck_fall;
  logic       tms;
  logic       tdi;
  logic       trst_n;
  logic       test_en;
  logic       tdo;
  logic [7:0] treg;
  modport ctl (input tck_rise, tck_fall, tms, tdi, trst_n, test_en, output tdo, treg);
  modport src (output tck_rise, tck_fall, tms, tdi, trst_n, test_en, input tdo, treg);
endinterface

// ### design/bsp_clkgen.sv
// Bus clock fan-out and feedback clock edge detect
`timescale 1ns/100ps
module bsp_clkgen
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     clk_in,
  input  wire logic                     gen_en,
  input  wire logic                     fb_in,
  input  wire logic [bsp_pkg::NCLK-1:0] mask,
  output logic      [bsp_pkg::NCLK-1:0] clk_out,
  output logic                          fb_rise
);
  typedef struct packed {
    logic                     ci1;
    logic                     ci2;
    logic                     en1;
    logic                     en2;
    logic                     fb1;
    logic                     fb2;
    logic                     fb3;
    logic [bsp_pkg::NCLK-1:0] out;
    logic                     rise;
  } bsp_cg_t;

  bsp_cg_t r_reg;
  bsp_cg_t r_next;

  always_comb
  begin
    r_next     = r_reg;
    r_next.ci1 = clk_in;
    r_next.ci2 = r_reg.ci1;
    r_next.en1 = gen_en;
    r_next.en2 = r_reg.en1;
    r_next.fb1 = fb_in;
    r_next.fb2 = r_reg.fb1;
    r_next.fb3 = r_reg.fb2;
    // Follows the input clock only well below half of aclk
    r_next.out  = r_reg.en2 ? ({bsp_pkg::NCLK{r_reg.ci2}} & mask) : '0;
    r_next.rise = r_reg.fb2 & ~r_reg.fb3;
    if (!aresetn)
    begin
      r_next = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    r_reg <= r_next;
  end

  assign clk_out = r_reg.out;
  assign fb_rise = r_reg.rise;
endmodule

// ### design/bsp_tap.sv
// Boundary-scan port controller with id, bypass and test registers
`timescale 1ns/100ps
module bsp_tap
(
  input  wire logic aclk,
  input  wire logic aresetn,
  bsp_tap_if.ctl    jt
);
  typedef struct packed {
    bsp_pkg::bsp_tap_st_t st;
    logic [3:0]           ir;
    logic [3:0]           irs;
    logic [31:0]          dr;
    logic [7:0]           treg;
    logic                 tdo;
  } bsp_tap_t;

  bsp_tap_t   r_reg;
  bsp_tap_t   r_next;
  logic [3:0] inst;
  logic       tms;

  always_comb
  begin
    r_next = r_reg;
    tms    = jt.tms;
    inst   = (r_reg.ir == bsp_pkg::IR_MFG && !jt.test_en) ? bsp_pkg::IR_BYPASS : r_reg.ir;
    if (jt.tck_rise)
    begin
      case (r_reg.st)
        bsp_pkg::ST_TLR:  r_next.st = tms ? bsp_pkg::ST_TLR  : bsp_pkg::ST_RTI;
        bsp_pkg::ST_RTI:  r_next.st = tms ? bsp_pkg::ST_SDR  : bsp_pkg::ST_RTI;
        bsp_pkg::ST_SDR:  r_next.st = tms ? bsp_pkg::ST_SIR  : bsp_pkg::ST_CDR;
        bsp_pkg::ST_CDR:  r_next.st = tms ? bsp_pkg::ST_E1DR : bsp_pkg::ST_SHDR;
        bsp_pkg::ST_SHDR: r_next.st = tms ? bsp_pkg::ST_E1DR : bsp_pkg::ST_SHDR;
        bsp_pkg::ST_E1DR: r_next.st = tms ? bsp_pkg::ST_UDR  : bsp_pkg::ST_PDR;
        bsp_pkg::ST_PDR:  r_next.st = tms ? bsp_pkg::ST_E2DR : bsp_pkg::ST_PDR;
        bsp_pkg::ST_E2DR: r_next.st = tms ? bsp_pkg::ST_UDR  : bsp_pkg::ST_SHDR;
        bsp_pkg::ST_UDR:  r_next.st = tms ? bsp_pkg::ST_SDR  : bsp_pkg::ST_RTI;
        bsp_pkg::ST_SIR:  r_next.st = tms ? bsp_pkg::ST_TLR  : bsp_pkg::ST_CIR;
        bsp_pkg::ST_CIR:  r_next.st = tms ? bsp_pkg::ST_E1IR : bsp_pkg::ST_SHIR;
        bsp_pkg::ST_SHIR: r_next.st = tms ? bsp_pkg::ST_E1IR : bsp_pkg::ST_SHIR;
        bsp_pkg::ST_E1IR: r_next.st = tms ? bsp_pkg::ST_UIR  : bsp_pkg::ST_PIR;
        bsp_pkg::ST_PIR:  r_next.st = tms ? bsp_pkg::ST_E2IR : bsp_pkg::ST_PIR;
        bsp_pkg::ST_E2IR: r_next.st = tms ? bsp_pkg::ST_UIR  : bsp_pkg::ST_SHIR;
        bsp_pkg::ST_UIR:  r_next.st = tms ? bsp_pkg::ST_SDR  : bsp_pkg::ST_RTI;
        default:          r_next.st = bsp_pkg::ST_TLR;
      endcase
      case (r_reg.st)
        bsp_pkg::ST_TLR:  r_next.ir  = bsp_pkg::IR_IDCODE;
        bsp_pkg::ST_CIR:  r_next.irs = bsp_pkg::IR_CAPT;
        bsp_pkg::ST_SHIR: r_next.irs = {jt.tdi, r_reg.irs[3:1]};
        bsp_pkg::ST_UIR:  r_next.ir  = r_reg.irs;
        bsp_pkg::ST_CDR:
          r_next.dr = (inst == bsp_pkg::IR_IDCODE) ? bsp_pkg::IDCODE_VAL :
                      (inst == bsp_pkg::IR_MFG) ? {24'h0, r_reg.treg} : '0;
        bsp_pkg::ST_SHDR:
          r_next.dr = (inst == bsp_pkg::IR_IDCODE) ? {jt.tdi, r_reg.dr[31:1]} :
                      (inst == bsp_pkg::IR_MFG) ? {24'h0, jt.tdi, r_reg.dr[7:1]} :
                      {31'h0, jt.tdi};
        bsp_pkg::ST_UDR:
          r_next.treg = (inst == bsp_pkg::IR_MFG) ? r_reg.dr[7:0] : r_reg.treg;
        default:          r_next.tdo = r_reg.tdo;
      endcase
    end
    else if (jt.tck_fall)
    begin
      r_next.tdo = (r_reg.st == bsp_pkg::ST_SHIR) ? r_reg.irs[0] : r_reg.dr[0];
    end
    if (!aresetn || !jt.trst_n)
    begin
      r_next    = '0;
      r_next.st = bsp_pkg::ST_TLR;
      r_next.ir = bsp_pkg::IR_IDCODE;
    end
  end

  always_ff @(posedge aclk)
  begin
    r_reg <= r_next;
  end

  assign jt.tdo  = r_reg.tdo;
  assign jt.treg = r_reg.treg;
endmodule

// ### design/bsp_top.sv
// Top of the strap capture, pin function select and scan port block
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module bsp_top
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [bsp_pkg::AW-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic      [1:0]             bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [bsp_pkg::AW-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic      [31:0]            rdata,
  output logic      [1:0]             rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic                   test_select_strap,
  input  wire logic                   serial_port_select_strap,
  input  wire logic                   transparency_strap,
  input  wire logic                   hotplug_mask_strap,
  input  wire logic                   direction_strap,
  input  wire logic                   central_function_strap,
  input  wire logic                   bus_reset_n,
  input  wire logic [5:0]             req_n_i,
  output logic      [5:0]             gnt_n_o,
  output logic      [5:0]             gnt_n_oe,
  output logic                        bus_park_oe,
  input  wire logic                   interrupt_line_a_n_i,
  output logic                        interrupt_line_a_n_o,
  output logic                        interrupt_line_a_n_oe,
  input  wire logic                   interrupt_line_b_n_i,
  output logic                        interrupt_line_b_n_o,
  output logic                        interrupt_line_b_n_oe,
  input  wire logic                   interrupt_line_c_n_i,
  output logic                        interrupt_line_c_n_o,
  output logic                        interrupt_line_c_n_oe,
  input  wire logic                   interrupt_line_d_n_i,
  output logic                        interrupt_line_d_n_o,
  output logic                        interrupt_line_d_n_oe,
  input  wire logic                   bus_clock_input,
  input  wire logic                   clock_generator_enable,
  input  wire logic                   feedback_clock_input,
  output logic      [6:0]             bus_clock_outputs,
  input  wire logic                   tck,
  input  wire logic                   tms,
  input  wire logic                   tdi,
  input  wire logic                   trst_n,
  output logic                        tdo,
  output logic                        test_mode,
  output logic                        smbus_mode,
  output logic                        nontransparent_mode,
  output logic                        reverse_mode,
  output logic                        external_arbiter,
  output logic                        hotplug_enable
);
  //------------------------------------------------------------
  // Types and state
  //------------------------------------------------------------
  typedef struct packed {
    bsp_pkg::bsp_mode_t strap;
    logic [5:0]         req_n;
    logic [3:0]         intl_n;
    logic               brst_n;
    logic               tck;
    logic               tms;
    logic               tdi;
    logic               trst_n;
  } bsp_pins_t;

  typedef struct packed {
    bsp_pins_t          p1;
    bsp_pins_t          p2;
    logic               tck_d;
    bsp_pkg::bsp_mode_t mode;
    logic [5:0]         gnt;
    logic [5:0]         gnt_n;
    logic               breq;
    logic [3:0]         general_outputs;
    logic [3:0]         intd;
    logic [6:0]         cmsk;
    logic               aw_ok;
    logic               w_ok;
    logic [7:0]         awa;
    logic [31:0]        wd;
    logic [3:0]         ws;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } bsp_state_t;

  typedef struct packed {
    logic [5:0] gnt;
    logic [3:0] intl;
    logic       park;
  } bsp_oe_t;

  bsp_state_t r;
  bsp_state_t n;
  bsp_oe_t    oe_reg;
  bsp_oe_t    oe_next;
  bsp_pins_t  pins;
  logic [5:0] req;
  logic [6:0] clk_mask;
  logic       fb_rise;
  logic       wr_hit;
  bsp_tap_if  jt ();

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
    sel = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    logic [31:0] v;
    v = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    wmerge = v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = sel(a, bsp_pkg::OFS_MODE) || sel(a, bsp_pkg::OFS_CTRL) ||
             sel(a, bsp_pkg::OFS_GPO) || sel(a, bsp_pkg::OFS_PINS) ||
             sel(a, bsp_pkg::OFS_INTD) || sel(a, bsp_pkg::OFS_CMSK);
  endfunction

  //------------------------------------------------------------
  // Pin gathering
  //------------------------------------------------------------
  assign pins.strap.hotplug  = hotplug_mask_strap;
  assign pins.strap.ext_arb  = central_function_strap;
  assign pins.strap.reverse  = direction_strap;
  assign pins.strap.nontrans = transparency_strap;
  assign pins.strap.smbus    = serial_port_select_strap;
  assign pins.strap.test     = test_select_strap;
  assign pins.req_n          = req_n_i;
  assign pins.intl_n         = {interrupt_line_d_n_i, interrupt_line_c_n_i,
                                interrupt_line_b_n_i, interrupt_line_a_n_i};
  assign pins.brst_n         = bus_reset_n;
  assign pins.tck            = tck;
  assign pins.tms            = tms;
  assign pins.tdi            = tdi;
  assign pins.trst_n         = trst_n;

  //------------------------------------------------------------
  // Main next-state logic
  //------------------------------------------------------------
  always_comb
  begin
    n      = r;
    n.p1   = pins;
    n.p2   = r.p1;
    n.tck_d = r.p2.tck;
    req    = ~r.p2.req_n;
    wr_hit = 1'b0;

    // Internal arbiter stepped by the feedback clock, or request and general outputs for an external arbiter
    if (r.mode.ext_arb)
    begin
      n.gnt   = '0;
      n.gnt_n = {r.general_outputs, 1'b1, ~r.breq};
    end
    else
    begin
      if (fb_rise && ((r.gnt & req) == '0))
      begin
        n.gnt = 6'(req & (~req + 6'h01));
      end
      n.gnt_n = ~n.gnt;
    end

    // Write address and data, in either order
    if (awvalid && r.awready)
    begin
      n.aw_ok = 1'b1;
      n.awa   = awaddr;
    end
    if (wvalid && r.wready)
    begin
      n.w_ok = 1'b1;
      n.wd   = wdata;
      n.ws   = wstrb;
    end
    if (r.bvalid && bready)
    begin
      n.bvalid = 1'b0;
    end
    if (r.aw_ok && r.w_ok && !r.bvalid)
    begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      wr_hit   = mapped(r.awa);
      n.bresp  = wr_hit ? bsp_pkg::RESP_OK : bsp_pkg::RESP_ERR;
      if (sel(r.awa, bsp_pkg::OFS_CTRL))
      begin
        n.breq = 1'(wmerge({31'h0, r.breq}, r.wd, r.ws));
      end
      if (sel(r.awa, bsp_pkg::OFS_GPO))
      begin
        n.general_outputs = 4'(wmerge({28'h0, r.general_outputs}, r.wd, r.ws));
      end
      if (sel(r.awa, bsp_pkg::OFS_INTD))
      begin
        // Drive held until software clears it
        n.intd = 4'(wmerge({28'h0, r.intd}, r.wd, r.ws));
      end
      if (sel(r.awa, bsp_pkg::OFS_CMSK))
      begin
        n.cmsk = 7'(wmerge({25'h0, r.cmsk}, r.wd, r.ws));
      end
    end

    // Read channel
    if (r.rvalid && rready)
    begin
      n.rvalid = 1'b0;
    end
    if (arvalid && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(araddr) ? bsp_pkg::RESP_OK : bsp_pkg::RESP_ERR;
      n.rdata  = '0;
      if (sel(araddr, bsp_pkg::OFS_MODE))
      begin
        n.rdata = {16'h0, jt.treg, 2'h0, r.mode};
      end
      else if (sel(araddr, bsp_pkg::OFS_CTRL))
      begin
        n.rdata = {31'h0, r.breq};
      end
      else if (sel(araddr, bsp_pkg::OFS_GPO))
      begin
        n.rdata = {28'h0, r.general_outputs};
      end
      else if (sel(araddr, bsp_pkg::OFS_PINS))
      begin
        n.rdata = {23'h0, ~r.p2.req_n[0], r.p2.intl_n, r.p2.req_n[5:2]};
      end
      else if (sel(araddr, bsp_pkg::OFS_INTD))
      begin
        n.rdata = {28'h0, r.intd};
      end
      else if (sel(araddr, bsp_pkg::OFS_CMSK))
      begin
        n.rdata = {25'h0, r.cmsk};
      end
    end

    n.awready = !n.aw_ok && !n.bvalid;
    n.wready  = !n.w_ok && !n.bvalid;
    n.arready = !n.rvalid;

    if (!aresetn)
    begin
      n       = '0;
      n.cmsk  = bsp_pkg::CMSK_RST;
      n.gnt_n = bsp_pkg::GNT_IDLE;
      n.p1    = pins;
      n.p2    = r.p1;
      n.mode  = r.p2.strap;
    end
  end

  always_ff @(posedge aclk)
  begin
    r <= n;
  end

  //------------------------------------------------------------
  // Output enables, cleared at once by bus reset
  //------------------------------------------------------------
  always_comb
  begin
    oe_next = '0;
    if (aresetn && r.p2.brst_n)
    begin
      oe_next.gnt  = '1;
      oe_next.intl = r.mode.reverse ? r.intd : '0;
      oe_next.park = !r.mode.ext_arb && (r.gnt == '0) && (req == '0);
    end
  end

  always_ff @(posedge aclk or negedge bus_reset_n)
  begin
    if (!bus_reset_n)
    begin
      oe_reg <= '0;
    end
    else
    begin
      oe_reg <= oe_next;
    end
  end

  //------------------------------------------------------------
  // Clocks and scan port
  //------------------------------------------------------------
  assign clk_mask = r.mode.hotplug ? r.cmsk : bsp_pkg::CMSK_RST;

  bsp_clkgen u_clk
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_in  (bus_clock_input),
    .gen_en  (clock_generator_enable),
    .fb_in   (feedback_clock_input),
    .mask    (clk_mask),
    .clk_out (bus_clock_outputs),
    .fb_rise (fb_rise)
  );

  assign jt.tck_rise = r.p2.tck & ~r.tck_d;
  assign jt.tck_fall = ~r.p2.tck & r.tck_d;
  assign jt.tms      = r.p2.tms;
  assign jt.tdi      = r.p2.tdi;
  assign jt.trst_n   = r.p2.trst_n;
  assign jt.test_en  = r.mode.test;

  bsp_tap u_tap
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .jt      (jt)
  );

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  assign awready               = r.awready;
  assign wready                = r.wready;
  assign bvalid                = r.bvalid;
  assign bresp                 = r.bresp;
  assign arready               = r.arready;
  assign rvalid                = r.rvalid;
  assign rresp                 = r.rresp;
  assign rdata                 = r.rdata;
  assign gnt_n_o               = r.gnt_n;
  assign gnt_n_oe              = oe_reg.gnt;
  assign bus_park_oe           = oe_reg.park;
  assign interrupt_line_a_n_o  = 1'b0;
  assign interrupt_line_b_n_o  = 1'b0;
  assign interrupt_line_c_n_o  = 1'b0;
  assign interrupt_line_d_n_o  = 1'b0;
  assign interrupt_line_a_n_oe = oe_reg.intl[0];
  assign interrupt_line_b_n_oe = oe_reg.intl[1];
  assign interrupt_line_c_n_oe = oe_reg.intl[2];
  assign interrupt_line_d_n_oe = oe_reg.intl[3];
  assign tdo                   = jt.tdo;
  assign test_mode             = r.mode.test;
  assign smbus_mode            = r.mode.smbus;
  assign nontransparent_mode   = r.mode.nontrans;
  assign reverse_mode          = r.mode.reverse;
  assign external_arbiter      = r.mode.ext_arb;
  assign hotplug_enable        = r.mode.hotplug;
endmodule

// ### verif/bsp_chk.sv
// Port-level checker of the strap and pin select block
`timescale 1ns/100ps
module bsp_chk
(
  input wire logic       aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic       arvalid, arready, rvalid, bus_reset_n, bus_park_oe, reverse_mode,
  input wire logic       clock_generator_enable, external_arbiter, test_mode, smbus_mode,
  input wire logic       nontransparent_mode, hotplug_enable, interrupt_line_a_n_oe,
  input wire logic       interrupt_line_b_n_oe, interrupt_line_c_n_oe, interrupt_line_d_n_oe,
  input wire logic [1:0] bresp,
  input wire logic [5:0] gnt_n_o, gnt_n_oe,
  input wire logic [6:0] bus_clock_outputs
);
  logic [5:0] md;
  logic [3:0] ioe;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign md = {hotplug_enable, external_arbiter, reverse_mode, nontransparent_mode,
               smbus_mode, test_mode};
  assign ioe = {interrupt_line_d_n_oe, interrupt_line_c_n_oe, interrupt_line_b_n_oe,
                interrupt_line_a_n_oe};
  // ----
  // Assertions
  // ----
  property p_mode_hold; $past(aresetn) |-> $stable(md); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_float; !bus_reset_n |-> gnt_n_oe == 6'h00 && !bus_park_oe; endproperty
  a_float: assert property (p_float) else $error("bus driven in reset");
  property p_fwd_int; !reverse_mode |-> ioe == 4'h0; endproperty
  a_fwd_int: assert property (p_fwd_int) else $error("forward int driven");
  property p_gen_off; !clock_generator_enable [*4] |-> bus_clock_outputs == 7'h00; endproperty
  a_gen_off: assert property (p_gen_off) else $error("clock not gated");
  property p_one_gnt; !external_arbiter |-> $onehot0(~gnt_n_o); endproperty
  a_one_gnt: assert property (p_one_gnt) else $error("two grants");
  property p_wr_ans; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_ans; arvalid && arready |=> rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
endmodule

// ### verif/bsp_arb_model.sv
// External bus arbiter model, prompt or slow
`timescale 1ns/100ps
module bsp_arb_model
(
  input  wire logic       aclk,
  input  wire logic       req_n,
  input  wire logic [3:0] dly,
  output logic            gnt_n
);
  int cnt = 0;
  initial gnt_n = 1'b1;
  always @(posedge aclk)
  begin
    cnt <= req_n ? 0 : cnt + 1;
    gnt_n <= req_n || cnt < int'(dly);
  end
endmodule

// ### verif/bsp_top_test.sv
// Self-checking bench of the strap and pin select block
`timescale 1ns/100ps
module bsp_top_test;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, bus_reset_n, bus_park_oe, bus_clock_input, clock_generator_enable;
  logic feedback_clock_input, tck, tms, tdi, trst_n, tdo, test_mode, smbus_mode, ag_n;
  logic nontransparent_mode, reverse_mode, external_arbiter, hotplug_enable;
  logic test_select_strap, serial_port_select_strap, transparency_strap, hotplug_mask_strap;
  logic direction_strap, central_function_strap, interrupt_line_a_n_i, interrupt_line_a_n_o;
  logic interrupt_line_a_n_oe, interrupt_line_b_n_i, interrupt_line_b_n_o, interrupt_line_b_n_oe;
  logic interrupt_line_c_n_i, interrupt_line_c_n_o, interrupt_line_c_n_oe, interrupt_line_d_n_i;
  logic interrupt_line_d_n_o, interrupt_line_d_n_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb, ix, oe, bc, dl;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  req_n_i, gnt_n_o, gnt_n_oe, rq, st;
  logic [6:0]  bus_clock_outputs;
  int          error_cnt, cmp_count, cyc;
  assign oe = {interrupt_line_d_n_oe, interrupt_line_c_n_oe, interrupt_line_b_n_oe,
               interrupt_line_a_n_oe};
  assign {interrupt_line_d_n_i, interrupt_line_c_n_i, interrupt_line_b_n_i,
          interrupt_line_a_n_i} = ix & ~oe;
  assign {hotplug_mask_strap, central_function_strap, direction_strap, transparency_strap,
          serial_port_select_strap, test_select_strap} = st;
  assign feedback_clock_input = bus_clock_outputs[0];
  assign bus_clock_input = bc[3];
  assign req_n_i = {rq[5:1], external_arbiter ? ag_n : rq[0]};
  bsp_top i_dut (.*);
  bsp_arb_model i_arb (.aclk(aclk), .req_n(gnt_n_o[0]), .dly(dl), .gnt_n(ag_n));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic rst(input logic [5:0] s);
    st <= s;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 1'b0; end
    join
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic ck(input logic [6:0] e);
    @(posedge bus_clock_input);
    repeat (5) @(posedge aclk);
    chk(bus_clock_outputs, e);
  endtask
  task automatic jb(input logic m);
    tck <= 1'b0;
    tms <= m;
    repeat (6) @(posedge aclk);
    v = {tdo, v[31:1]};
    tck <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask
  task automatic t_straps;
    logic [5:0] pt [3];
    pt = '{6'h15, 6'h2a, 6'h00};
    for (int i = 0; i < 3; i++)
    begin
      rst(pt[i]);
      st <= ~pt[i];
      repeat (6) @(posedge aclk);
      rd(bsp_pkg::OFS_MODE);
      chk(v[5:0], pt[i]);
      chk({hotplug_enable, external_arbiter, reverse_mode, nontransparent_mode, smbus_mode,
           test_mode}, pt[i]);
    end
    wr(8'h18, 32'h0);
    chk(r, bsp_pkg::RESP_ERR);
    rd(8'h18);
    chk(r, bsp_pkg::RESP_ERR);
    $display("straps test done");
  endtask
  task automatic t_ext;
    rst(6'h10);
    for (int d = 0; d < 8; d += 7)
    begin
      dl <= 4'(d);
      wr(bsp_pkg::OFS_CTRL, 32'h1);
      repeat (20) @(posedge aclk);
      chk(gnt_n_o[0], 1'b0);
      rd(bsp_pkg::OFS_PINS);
      chk(v[8], 1'b1);
      wr(bsp_pkg::OFS_CTRL, 32'h0);
      repeat (20) @(posedge aclk);
      rd(bsp_pkg::OFS_PINS);
      chk(v[8], 1'b0);
    end
    rq <= 6'h1b;
    wr(bsp_pkg::OFS_GPO, 32'ha);
    repeat (6) @(posedge aclk);
    chk(gnt_n_o[5:2], 4'ha);
    rd(bsp_pkg::OFS_PINS);
    chk(v[3:0], 4'h6);
    rq <= 6'h3f;
    $display("external arbiter test done");
  endtask
  task automatic t_int;
    for (int k = 1; k >= 0; k--)
    begin
      rst(k ? 6'h08 : 6'h00);
      ix <= k ? 4'hf : 4'h6;
      wr(bsp_pkg::OFS_INTD, 32'h9);
      chk(r, bsp_pkg::RESP_OK);
      chk({interrupt_line_d_n_o, interrupt_line_c_n_o, interrupt_line_b_n_o,
           interrupt_line_a_n_o}, 4'h0);
      repeat (6) @(posedge aclk);
      chk(oe, k ? 4'h9 : 4'h0);
      rd(bsp_pkg::OFS_PINS);
      chk(v[7:4], 4'h6);
    end
    $display("interrupt test done");
  endtask
  task automatic t_arb;
    rst(6'h20);
    wr(bsp_pkg::OFS_CMSK, 32'h5);
    ck(7'h05);
    rst(6'h00);
    ck(7'h7f);
    clock_generator_enable <= 1'b0;
    ck(7'h00);
    clock_generator_enable <= 1'b1;
    rq <= 6'h2b;
    repeat (60) @(posedge aclk);
    chk(gnt_n_o, 6'h3b);
    rq <= 6'h3f;
    repeat (60) @(posedge aclk);
    chk(bus_park_oe, 1'b1);
    bus_reset_n <= 1'b0;
    @(posedge aclk);
    chk({gnt_n_oe, bus_park_oe}, 7'h00);
    bus_reset_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(bus_park_oe, 1'b1);
    $display("clock and arbiter test done");
  endtask
  task automatic t_tap;
    for (int p = 0; p < 2; p++)
    begin
      trst_n <= 1'b0;
      jb(1'b1);
      trst_n <= 1'b1;
      jb(1'b0);
      jb(1'b1);
      jb(1'b0);
      jb(1'b0);
      for (int i = 0; i < 32; i++)
        jb(i == 31);
      chk(v, bsp_pkg::IDCODE_VAL);
    end
    $display("scan test done");
  endtask
  // ----
  // Clock, timeout and sequence
  // ----
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    bc <= bc + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, bus_reset_n, clock_generator_enable} = 7'h03;
    {awaddr, araddr, wdata, tck, tms, tdi, trst_n} = '0;
    {wstrb, ix, rq, st, bc, dl, aresetn} = {8'hff, 6'h3f, 6'h00, 8'h00, 1'b0};
    rst(6'h00);
    t_straps;
    t_ext;
    t_int;
    t_arb;
    t_tap;
    tally_and_finish;
  end
endmodule
bind bsp_top bsp_chk i_chk (.*);
